// ### hw/cps_core.sv
`timescale 1ns/1ps
`include "cps_defs.svh"
module cps_core #(
   parameter int unsigned OVERCHARGE_CYCLES =
      `CPS_MS_CYCLES(`CPS_OVERCHARGE_DELAY_MS),
   parameter int unsigned OVERDISCHARGE_CYCLES =
      `CPS_MS_CYCLES(`CPS_OVERDISCHARGE_DELAY_MS),
   parameter int unsigned FIRST_OC_CYCLES =
      `CPS_US_CYCLES(`CPS_FIRST_OC_DELAY_US),
   parameter int unsigned SECOND_OC_CYCLES =
      `CPS_US_CYCLES(`CPS_SECOND_OC_DELAY_US),
   parameter int unsigned CHARGE_OC_CYCLES =
      `CPS_MS_CYCLES(`CPS_CHARGE_OC_DELAY_MS)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire cps_pkg::cps_cmp_t cmp_i,
   output logic charge_switch_on_o,
   output logic discharge_switch_on_o
);
   cps_pkg::cps_state_t r;
   cps_pkg::cps_state_t next_r;

   // ----------------------------------------
   // qualification counters
   // ----------------------------------------
   function automatic logic [31:0] qual(input logic cond,
                                        input logic [31:0] cnt,
                                        input logic [31:0] lim);
      // saturates at the limit; any gap restarts it
      if (!cond) begin
         qual = `CPS_CNT_ZERO; // see R17
      end else if (cnt >= lim) begin
         qual = cnt;
      end else begin
         qual = cnt + `CPS_CNT_ONE;
      end
   endfunction

   logic oc_done, od_done, oi1_done, oi2_done, coc_done;
   always_comb begin
      oc_done = r.cnt_oc >= OVERCHARGE_CYCLES;
      od_done = r.cnt_od >= OVERDISCHARGE_CYCLES; // see R7
      oi1_done = r.cnt_oi1 >= FIRST_OC_CYCLES; // see R15
      oi2_done = r.cnt_oi2 >= SECOND_OC_CYCLES; // see R16
      coc_done = r.cnt_coc >= CHARGE_OC_CYCLES;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      // three stages; a change counts once stage two and three agree
      next_r.sync1 = cmp_i;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      if (r.sync2 == r.sync3) begin
         next_r.cmp = r.sync3;
      end
      next_r.cnt_oc = qual(r.chg == cps_pkg::CPS_CHG_NORMAL &&
         r.cmp.above_overcharge_detect, r.cnt_oc,
         OVERCHARGE_CYCLES); // see R2
      next_r.cnt_coc = qual(r.chg == cps_pkg::CPS_CHG_NORMAL &&
         r.cmp.below_charge_overcurrent, r.cnt_coc,
         CHARGE_OC_CYCLES); // see R12
      next_r.cnt_od = qual(r.dsg == cps_pkg::CPS_DSG_NORMAL &&
         r.cmp.below_overdischarge_detect, r.cnt_od,
         OVERDISCHARGE_CYCLES); // see R6
      next_r.cnt_oi1 = qual(r.dsg == cps_pkg::CPS_DSG_NORMAL &&
         r.cmp.above_low_overcurrent, r.cnt_oi1,
         FIRST_OC_CYCLES); // see R9 R11
      next_r.cnt_oi2 = qual(r.dsg == cps_pkg::CPS_DSG_NORMAL &&
         r.cmp.above_high_overcurrent, r.cnt_oi2,
         SECOND_OC_CYCLES); // see R11

      // charge side only drives the charge switch
      unique case (r.chg) // see R18
         cps_pkg::CPS_CHG_NORMAL: begin
            if (oc_done) begin
               next_r.chg = cps_pkg::CPS_CHG_OVERCHARGE; // see R2
            end else if (coc_done) begin
               next_r.chg = cps_pkg::CPS_CHG_OVERCURRENT; // see R12
            end
         end
         cps_pkg::CPS_CHG_OVERCHARGE: begin
            // held while above detect even with a load, see R5
            if (r.cmp.below_overcharge_release) begin
               next_r.chg = cps_pkg::CPS_CHG_NORMAL; // see R3
            end else if (!r.cmp.above_overcharge_detect &&
                         r.cmp.load_present) begin
               next_r.chg = cps_pkg::CPS_CHG_NORMAL; // see R4
            end
         end
         cps_pkg::CPS_CHG_OVERCURRENT: begin
            if (!r.cmp.below_charge_overcurrent) begin
               next_r.chg = cps_pkg::CPS_CHG_NORMAL; // see R13
            end
         end
         default: next_r.chg = cps_pkg::CPS_CHG_NORMAL;
      endcase

      unique case (r.dsg) // see R18
         cps_pkg::CPS_DSG_NORMAL: begin
            if (od_done) begin
               next_r.dsg = cps_pkg::CPS_DSG_OVERDISCHARGE; // see R6
            end else if (oi1_done || oi2_done) begin
               next_r.dsg = cps_pkg::CPS_DSG_OVERCURRENT; // see R9 R11
            end
         end
         cps_pkg::CPS_DSG_OVERDISCHARGE: begin
            // no power-down: level is the only way out
            if (r.cmp.above_overdischarge_release) begin
               next_r.dsg = cps_pkg::CPS_DSG_NORMAL; // see R8 R14
            end
         end
         cps_pkg::CPS_DSG_OVERCURRENT: begin
            if (r.cmp.load_removed) begin
               next_r.dsg = cps_pkg::CPS_DSG_NORMAL; // see R10
            end
         end
         default: next_r.dsg = cps_pkg::CPS_DSG_NORMAL;
      endcase

      // both on whenever neither side is latched
      next_r.charge_on = next_r.chg == cps_pkg::CPS_CHG_NORMAL; // see R1
      next_r.discharge_on =
         next_r.dsg == cps_pkg::CPS_DSG_NORMAL; // see R1
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.charge_on <= 1'b1;
         r.discharge_on <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign charge_switch_on_o = r.charge_on;
   assign discharge_switch_on_o = r.discharge_on;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_oc_qualified;
      r.chg == cps_pkg::CPS_CHG_NORMAL && oc_done;
   endsequence

   AST_OC_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      s_oc_qualified |=> !charge_switch_on_o) // see R2
      else $error("overcharge did not turn charge switch off");
   AST_OC_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_OVERCHARGE && r.cmp.below_overcharge_release
      |=> charge_switch_on_o) // see R3
      else $error("overcharge did not release");
   AST_OC_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_OVERCHARGE && !r.cmp.above_overcharge_detect
      && r.cmp.load_present |=> charge_switch_on_o) // see R4
      else $error("load did not release overcharge");
   AST_OC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_OVERCHARGE && r.cmp.above_overcharge_detect
      |=> !charge_switch_on_o) // see R5
      else $error("overcharge released above detect level");
   AST_OD_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_NORMAL && od_done
      |=> !discharge_switch_on_o) // see R6
      else $error("overdischarge did not turn discharge off");
   AST_OD_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_OVERDISCHARGE &&
      r.cmp.above_overdischarge_release |=> discharge_switch_on_o) // see R8
      else $error("overdischarge did not release at once");
   AST_OD_STAY: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_OVERDISCHARGE &&
      !r.cmp.above_overdischarge_release |=> !discharge_switch_on_o) // see R14
      else $error("overdischarge left without release level");
   AST_OI_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_OVERCURRENT && r.cmp.load_removed
      |=> discharge_switch_on_o) // see R10
      else $error("overcurrent did not clear on load removal");
   AST_OI2: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_NORMAL && oi2_done && !od_done
      |=> r.dsg == cps_pkg::CPS_DSG_OVERCURRENT) // see R11
      else $error("high overcurrent not taken");
   AST_COC: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_OVERCURRENT && !r.cmp.below_charge_overcurrent
      |=> charge_switch_on_o) // see R13
      else $error("charge overcurrent did not clear");
   AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cmp.above_low_overcurrent |=> r.cnt_oi1 == `CPS_CNT_ZERO) // see R17
      else $error("counter did not restart");
   AST_SPLIT: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_NORMAL |-> charge_switch_on_o) // see R18
      else $error("charge switch off with no charge fault");

   AST_DSG_SPLIT: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_NORMAL |-> discharge_switch_on_o) // see R18
      else $error("discharge switch off with no discharge fault");

   // ----------------------------------------
   // entry and hold
   // ----------------------------------------
   // overcharge and overdischarge entries are checked on state and gate, charge and low overcurrent on the gate only
   sequence s_coc_qualified;
      r.chg == cps_pkg::CPS_CHG_NORMAL && coc_done && !oc_done;
   endsequence
   sequence s_oi1_qualified;
      r.dsg == cps_pkg::CPS_DSG_NORMAL && oi1_done && !od_done;
   endsequence
   sequence s_od_qualified;
      r.dsg == cps_pkg::CPS_DSG_NORMAL && od_done;
   endsequence
   sequence s_chg_quiet;
      r.chg == cps_pkg::CPS_CHG_NORMAL && !oc_done && !coc_done;
   endsequence
   sequence s_dsg_quiet;
      r.dsg == cps_pkg::CPS_DSG_NORMAL && !od_done && !oi1_done && !oi2_done;
   endsequence

   AST_OC_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
      s_oc_qualified |=> r.chg == cps_pkg::CPS_CHG_OVERCHARGE) // see R2
      else $error("overcharge lost to charge overcurrent");

   AST_COC_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      s_coc_qualified |=> !charge_switch_on_o) // see R12
      else $error("charge overcurrent did not turn charge off");

   AST_OD_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
      s_od_qualified |=> r.dsg == cps_pkg::CPS_DSG_OVERDISCHARGE) // see R6
      else $error("overdischarge lost to overcurrent");

   AST_OI1_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      s_oi1_qualified |=> !discharge_switch_on_o) // see R9
      else $error("low overcurrent did not turn discharge off");

   AST_OI_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg == cps_pkg::CPS_DSG_OVERCURRENT && !r.cmp.load_removed
      |=> !discharge_switch_on_o) // see R10
      else $error("overcurrent cleared with load still present");

   AST_COC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg == cps_pkg::CPS_CHG_OVERCURRENT && r.cmp.below_charge_overcurrent
      |=> !charge_switch_on_o) // see R13
      else $error("charge overcurrent cleared with charger present");

   AST_CHG_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
      s_chg_quiet |=> charge_switch_on_o) // see R17
      else $error("charge switch off before a delay expired");

   AST_DSG_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
      s_dsg_quiet |=> discharge_switch_on_o) // see R17
      else $error("discharge switch off before a delay expired");

   // ----------------------------------------
   // counters
   // ----------------------------------------
   // a count that survived a gap would let short bursts add up
   AST_RESTART_OC: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cmp.above_overcharge_detect |=> r.cnt_oc == `CPS_CNT_ZERO) // see R17
      else $error("overcharge counter did not restart");

   AST_RESTART_OD: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cmp.below_overdischarge_detect |=> r.cnt_od == `CPS_CNT_ZERO) // see R17
      else $error("overdischarge counter did not restart");

   AST_RESTART_OI2: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cmp.above_high_overcurrent |=> r.cnt_oi2 == `CPS_CNT_ZERO) // see R17
      else $error("high overcurrent counter did not restart");

   AST_RESTART_COC: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cmp.below_charge_overcurrent |=> r.cnt_coc == `CPS_CNT_ZERO) // see R17
      else $error("charge overcurrent counter did not restart");

   AST_SAT_OC: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cnt_oc <= OVERCHARGE_CYCLES) // see R2
      else $error("overcharge counter ran past its limit");

   AST_SAT_OD: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cnt_od <= OVERDISCHARGE_CYCLES) // see R7
      else $error("overdischarge counter ran past its limit");

   AST_SAT_OI1: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cnt_oi1 <= FIRST_OC_CYCLES) // see R15
      else $error("low overcurrent counter ran past its limit");

   AST_SAT_OI2: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cnt_oi2 <= SECOND_OC_CYCLES) // see R16
      else $error("high overcurrent counter ran past its limit");

   AST_SAT_COC: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cnt_coc <= CHARGE_OC_CYCLES) // see R12
      else $error("charge overcurrent counter ran past its limit");

   // ----------------------------------------
   // filter, reset and state codes
   // ----------------------------------------
   // a level still settling in the synchroniser must not reach the logic
   AST_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
      r.sync2 != r.sync3 |=> r.cmp == $past(r.cmp))
      else $error("filtered levels changed while stages disagreed");

   AST_RESET_ON: assert property (@(posedge clk_i)
      rst_i |=> charge_switch_on_o && discharge_switch_on_o) // see R1
      else $error("switches not on after reset");

   AST_CHG_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
      r.chg inside {cps_pkg::CPS_CHG_NORMAL, cps_pkg::CPS_CHG_OVERCHARGE,
      cps_pkg::CPS_CHG_OVERCURRENT}) // see R18
      else $error("charge side state code illegal");

   AST_DSG_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
      r.dsg inside {cps_pkg::CPS_DSG_NORMAL, cps_pkg::CPS_DSG_OVERDISCHARGE,
      cps_pkg::CPS_DSG_OVERCURRENT}) // see R18
      else $error("discharge side state code illegal");
endmodule

// ### hw/cps_defs.svh
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH
// How it works
// R1: in-range cell and sense: both switches on
// R2: sustained overcharge turns charge switch off
// R3: overcharge releases below release level
// R4: overcharge releases below detect with load
// R5: overcharge holds above detect despite load
// R6: sustained overdischarge turns discharge switch off
// R7: overdischarge delay defaults to 10 ms
// R8: overdischarge ends at once above release
// R9: sustained first overcurrent turns discharge off
// R10: overcurrent clears when load is removed
// R11: two overcurrent levels, each own delay
// R12: sustained charge overcurrent turns charge off
// R13: charge overcurrent clears when sense recovers
// R14: overdischarge stays awake, releases on level only
// R15: first overcurrent delay 20.0 ms typical
// R16: second overcurrent delay 1.0 ms typical
// R17: delay counters restart when fault drops
// R18: charge and discharge faults act independently

// ----------------------------------------
// timing
// ----------------------------------------
`define CPS_CLK_PERIOD_NS 4
`define CPS_OVERCHARGE_DELAY_MS 200
`define CPS_OVERDISCHARGE_DELAY_MS 10
`define CPS_FIRST_OC_DELAY_US 20000
`define CPS_SECOND_OC_DELAY_US 1000
`define CPS_CHARGE_OC_DELAY_MS 32
`define CPS_MS_CYCLES(ms) ((ms) * 1000000 / `CPS_CLK_PERIOD_NS)
`define CPS_US_CYCLES(us) ((us) * 1000 / `CPS_CLK_PERIOD_NS)
`define CPS_CNT_W 32
`define CPS_SYNC_W 3
`define CPS_CMP_W 9
`define CPS_CNT_ZERO 32'h0000_0000
`define CPS_CNT_ONE 32'h0000_0001
`endif

// ### hw/cps_pkg.sv
package cps_pkg;
   // comparator outputs, each high when the condition named holds
   typedef struct packed {
      logic above_overcharge_detect;
      logic below_overcharge_release;
      logic below_overdischarge_detect;
      logic above_overdischarge_release;
      logic above_low_overcurrent;
      logic above_high_overcurrent;
      logic below_charge_overcurrent;
      logic load_present;
      logic load_removed;
   } cps_cmp_t;

   typedef enum logic [1:0] {
      CPS_CHG_NORMAL,
      CPS_CHG_OVERCHARGE,
      CPS_CHG_OVERCURRENT
   } cps_chg_state_t;

   typedef enum logic [1:0] {
      CPS_DSG_NORMAL,
      CPS_DSG_OVERDISCHARGE,
      CPS_DSG_OVERCURRENT
   } cps_dsg_state_t;

   typedef struct packed {
      logic [8:0] sync1;
      logic [8:0] sync2;
      logic [8:0] sync3;
      cps_cmp_t cmp;
      cps_chg_state_t chg;
      cps_dsg_state_t dsg;
      logic [31:0] cnt_oc;
      logic [31:0] cnt_od;
      logic [31:0] cnt_oi1;
      logic [31:0] cnt_oi2;
      logic [31:0] cnt_coc;
      logic charge_on;
      logic discharge_on;
   } cps_state_t;
endpackage

// ### tb/cell_protection_state_machine_tb_top.sv
`timescale 1ns/1ps
module cell_protection_state_machine_tb_top;
   // short delays keep the run brief; second overcurrent well below first
   localparam int OC_N = 20, OD_N = 10, OI1_N = 40, OI2_N = 4, COC_N = 12;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic signed [15:0] cell_mv = 16'sd3700;
   logic signed [15:0] sense_mv = 16'sd0;
   logic load = 1'b0;
   cps_pkg::cps_cmp_t cmp;
   logic chg_on, dis_on;
   int err_total = 0;
   int checks_done = 0;

   cps_cmp_model i_cmp (.cell_mv_i(cell_mv), .sense_mv_i(sense_mv),
      .load_i(load), .cmp_o(cmp));
   cps_core #(.OVERCHARGE_CYCLES(OC_N), .OVERDISCHARGE_CYCLES(OD_N),
      .FIRST_OC_CYCLES(OI1_N), .SECOND_OC_CYCLES(OI2_N),
      .CHARGE_OC_CYCLES(COC_N)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cmp_i(cmp), .charge_switch_on_o(chg_on),
      .discharge_switch_on_o(dis_on));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic drive(input int c, input int s, input logic l);
      @(negedge clk_i);
      cell_mv = 16'(c);
      sense_mv = 16'(s);
      load = l;
   endtask

   // waits for a switch to reach val; too early a change is an error
   task automatic trip(input bit dsg, input logic val, input int lo,
      input int hi, input string what);
      int n;
      n = 0;
      while (((dsg ? dis_on : chg_on) !== val) && n < hi) begin
         @(negedge clk_i);
         n++;
      end
      chk(what, val, dsg ? dis_on : chg_on);
      chk({what, " not early"}, 1'b1, 1'(n >= lo));
   endtask

   task automatic t_overcharge();
      chk("both on", 1'b1, chg_on & dis_on);
      drive(4300, 0, 0);
      trip(0, 1'b0, OC_N, OC_N + 12, "oc trip");
      chk("dsg kept", 1'b1, dis_on);
      drive(4300, 0, 1);
      repeat (30) @(negedge clk_i);
      chk("oc held", 1'b0, chg_on);
      drive(4200, 0, 1);
      trip(0, 1'b1, 0, 8, "load release");
      drive(4300, 0, 0);
      trip(0, 1'b0, OC_N, OC_N + 12, "oc trip2");
      drive(4000, 0, 0);
      trip(0, 1'b1, 0, 8, "level release");
      $display("test overcharge done");
   endtask

   task automatic t_glitch();
      repeat (4) begin
         drive(4300, 0, 0);
         repeat (OC_N / 2) @(negedge clk_i);
         drive(3700, 0, 0);
         repeat (6) @(negedge clk_i);
      end
      chk("interrupted", 1'b1, chg_on);
      $display("test glitch done");
   endtask

   task automatic t_overdischarge();
      drive(2300, 0, 0);
      trip(1, 1'b0, OD_N, OD_N + 12, "od trip");
      chk("chg kept", 1'b1, chg_on);
      drive(2450, 0, 0);
      repeat (200) @(negedge clk_i);
      chk("od held", 1'b0, dis_on);
      drive(2600, 0, 0);
      trip(1, 1'b1, 0, 7, "od release");
      $display("test overdischarge done");
   endtask

   task automatic t_overcurrent();
      drive(3700, 200, 1);
      trip(1, 1'b0, OI1_N, OI1_N + 12, "low oi");
      drive(3700, 0, 1);
      repeat (20) @(negedge clk_i);
      chk("oi held", 1'b0, dis_on);
      drive(3700, 0, 0);
      trip(1, 1'b1, 0, 7, "oi release");
      drive(3700, 1400, 1);
      trip(1, 1'b0, OI2_N, OI2_N + 12, "high oi");
      drive(3700, 0, 0);
      trip(1, 1'b1, 0, 7, "oi release2");
      $display("test overcurrent done");
   endtask

   task automatic t_charge_oc();
      drive(3700, -200, 0);
      trip(0, 1'b0, COC_N, COC_N + 12, "coc trip");
      chk("dsg kept2", 1'b1, dis_on);
      drive(3700, 0, 0);
      trip(0, 1'b1, 0, 7, "coc release");
      $display("test charge overcurrent done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (8) @(negedge clk_i);
      t_overcharge();
      t_glitch();
      t_overdischarge();
      t_overcurrent();
      t_charge_oc();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
endmodule

// ### tb/cps_cmp_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// comparator front end, levels in millivolts
// ---------------------------------------------
// sense is signed: negative while a charger pushes current in
module cps_cmp_model (
   input wire logic signed [15:0] cell_mv_i,
   input wire logic signed [15:0] sense_mv_i,
   input wire logic load_i,
   output cps_pkg::cps_cmp_t cmp_o
);
   always_comb begin
      cmp_o.above_overcharge_detect = cell_mv_i > 16'sd4280;
      cmp_o.below_overcharge_release = cell_mv_i < 16'sd4080;
      cmp_o.below_overdischarge_detect = cell_mv_i < 16'sd2400;
      cmp_o.above_overdischarge_release = cell_mv_i > 16'sd2500;
      cmp_o.above_low_overcurrent = sense_mv_i > 16'sd150;
      cmp_o.above_high_overcurrent = sense_mv_i > 16'sd1350;
      cmp_o.below_charge_overcurrent = sense_mv_i < -16'sd150;
      cmp_o.load_present = load_i;
      // open pack terminals read as high impedance
      cmp_o.load_removed = !load_i;
   end
endmodule
